// *** src/trcr_core.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - Local result byte at 0x00, one degree.
// - Remote integer at 0x01, fraction at 0x10.
// - Fraction uses bits 7:6, rest zero.
// - Fraction read locks integer until read.
// - Setup bit 2 selects extended range.
// - New range valid from next measurement cycle.
// - Shorted diode keeps last good remote result.
// - Extended range stores temperature plus 64.
// - Setup bit 7 masks alarm, resets 0.
// - Setup bit 6 selects standby, resets 0.
// - Setup bit 5 sets shared pin role.
// - Rate read at 0x04, written at 0x0A.
// - Rate code halves interval from 16 s.
// - Rate register resets to 0x08.
// - Each interval outside standby converts local then remote.
// - First write byte loads pointer, second writes.
module trcr_core #(
  parameter longint SLOW_CYCLES = trcr_pkg::SLOWEST_INTERVAL_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_valid,
  input wire trcr_pkg::trcr_wr_byte_t wr_byte,
  input wire logic rd_req,
  output logic [7:0] rd_data,
  output logic conv_req,
  output logic conv_remote,
  input wire logic adc_done,
  input wire trcr_pkg::trcr_adc_t adc_result,
  output logic results_updated,
  output logic alarm_mask_bit,
  output logic shared_pin_role_select,
  output logic standby,
  output logic extended_range
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] interval_of(input logic [3:0] code);
    logic [3:0] c;
    c = (code > trcr_pkg::RATE_CODE_MAX) ? trcr_pkg::RATE_CODE_MAX : code;
    interval_of = 32'(SLOW_CYCLES >> c);
  endfunction : interval_of

  function automatic logic [7:0] format_int(input logic signed [9:0] t, input logic ext);
    logic signed [9:0] whole;
    logic signed [9:0] v;
    whole = t >>> 2;
    v = ext ? whole + $signed(trcr_pkg::EXT_OFFSET) : whole;
    if (v < 0) begin
      format_int = 8'h00;
    end else if (!ext && v > $signed(trcr_pkg::DEF_MAX)) begin
      format_int = trcr_pkg::DEF_MAX[7:0];
    end else if (v > $signed(trcr_pkg::EXT_MAX)) begin
      format_int = trcr_pkg::EXT_MAX[7:0];
    end else begin
      format_int = v[7:0];
    end
  endfunction : format_int

  // ****************************************************************
  // Register pointer and host writes
  // ****************************************************************
  logic [7:0] ptr_r;
  logic [7:0] setup_r;
  logic [7:0] rate_r;
  logic data_wr;

  assign data_wr = wr_valid && !wr_byte.first;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_r <= 8'h00;
    end else if (wr_valid && wr_byte.first) begin
      ptr_r <= wr_byte.data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      setup_r <= trcr_pkg::SETUP_RESET;
    end else if (data_wr && ptr_r == trcr_pkg::PTR_SETUP_WR) begin
      setup_r <= wr_byte.data & trcr_pkg::SETUP_WRITABLE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rate_r <= trcr_pkg::RATE_RESET;
    end else if (data_wr && ptr_r == trcr_pkg::PTR_RATE_WR) begin
      rate_r <= wr_byte.data;
    end
  end

  assign alarm_mask_bit = setup_r[trcr_pkg::SETUP_MASK_BIT];
  assign standby = setup_r[trcr_pkg::SETUP_STANDBY_BIT];
  assign shared_pin_role_select = setup_r[trcr_pkg::SETUP_ROLE_BIT];
  assign extended_range = setup_r[trcr_pkg::SETUP_RANGE_BIT];

  // ****************************************************************
  // Interval timer
  // ****************************************************************
  logic [31:0] timer_r;
  logic tick;

  assign tick = (timer_r == 32'h0);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_r <= 32'h0;
    end else if (tick) begin
      timer_r <= interval_of(rate_r[3:0]) - 32'h1;
    end else begin
      timer_r <= timer_r - 32'h1;
    end
  end

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  localparam trcr_pkg::trcr_state_t TRCR_IDLE_S = trcr_pkg::TRCR_IDLE;

  trcr_pkg::trcr_state_t state_r;
  logic range_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= TRCR_IDLE_S;
    end else begin
      case (state_r)
        TRCR_IDLE_S: begin
          if (tick && !standby) begin
            state_r <= trcr_pkg::TRCR_LOCAL;
          end
        end
        trcr_pkg::TRCR_LOCAL: begin
          if (adc_done) begin
            state_r <= trcr_pkg::TRCR_REMOTE;
          end
        end
        trcr_pkg::TRCR_REMOTE: begin
          if (adc_done) begin
            state_r <= TRCR_IDLE_S;
          end
        end
        default: begin
          state_r <= TRCR_IDLE_S;
        end
      endcase
    end
  end

  // Range is frozen per measurement cycle so a change applies to the next one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      range_r <= 1'b0;
    end else if (state_r == TRCR_IDLE_S && tick && !standby) begin
      range_r <= extended_range;
    end
  end

  // Request pulses once on entering each channel state
  logic req_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_r <= 1'b0;
    end else begin
      req_r <= (state_r == TRCR_IDLE_S && tick && !standby) ||
               (state_r == trcr_pkg::TRCR_LOCAL && adc_done);
    end
  end

  assign conv_req = req_r;
  assign conv_remote = (state_r == trcr_pkg::TRCR_REMOTE);

  // ****************************************************************
  // Result registers
  // ****************************************************************
  logic [7:0] local_r;
  logic [7:0] remote_int_r;
  logic [7:0] remote_frac_r;
  logic lock_r;
  logic rd_frac;
  logic rd_int;
  logic local_done;
  logic remote_done;
  logic upd_r;

  assign rd_frac = rd_req && ptr_r == trcr_pkg::PTR_REMOTE_FRAC_RD;
  assign rd_int = rd_req && ptr_r == trcr_pkg::PTR_REMOTE_INT_RD;
  assign local_done = adc_done && state_r == trcr_pkg::TRCR_LOCAL;
  assign remote_done = adc_done && state_r == trcr_pkg::TRCR_REMOTE && !adc_result.diode_short;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      local_r <= trcr_pkg::RESULT_RESET;
    end else if (local_done) begin
      local_r <= format_int(adc_result.temp, range_r);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      remote_frac_r <= trcr_pkg::RESULT_RESET;
    end else if (remote_done) begin
      remote_frac_r <= {adc_result.temp[1:0], 6'h00};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      remote_int_r <= trcr_pkg::RESULT_RESET;
    end else if (remote_done && !lock_r) begin
      remote_int_r <= format_int(adc_result.temp, range_r);
    end
  end

  // Fraction read sets the lock; a simultaneous integer read cannot occur
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_r <= 1'b0;
    end else if (rd_frac) begin
      lock_r <= 1'b1;
    end else if (rd_int) begin
      lock_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      upd_r <= 1'b0;
    end else begin
      upd_r <= adc_done && state_r == trcr_pkg::TRCR_REMOTE;
    end
  end

  assign results_updated = upd_r;

  // ****************************************************************
  // Read port
  // ****************************************************************
  logic [7:0] rd_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_r <= 8'h00;
    end else if (rd_req) begin
      case (ptr_r)
        trcr_pkg::PTR_LOCAL_RD: rd_r <= local_r;
        trcr_pkg::PTR_REMOTE_INT_RD: rd_r <= remote_int_r;
        trcr_pkg::PTR_SETUP_RD: rd_r <= setup_r;
        trcr_pkg::PTR_RATE_RD: rd_r <= rate_r;
        trcr_pkg::PTR_REMOTE_FRAC_RD: rd_r <= remote_frac_r;
        default: rd_r <= 8'h00;
      endcase
    end
  end

  assign rd_data = rd_r;

endmodule : trcr_core

// *** src/trcr_pkg.sv ***
package trcr_pkg;

  // ****************************************************************
  // Register pointer values
  // ****************************************************************
  localparam logic [7:0] PTR_LOCAL_RD = 8'h00;
  localparam logic [7:0] PTR_REMOTE_INT_RD = 8'h01;
  localparam logic [7:0] PTR_SETUP_RD = 8'h03;
  localparam logic [7:0] PTR_RATE_RD = 8'h04;
  localparam logic [7:0] PTR_SETUP_WR = 8'h09;
  localparam logic [7:0] PTR_RATE_WR = 8'h0A;
  localparam logic [7:0] PTR_REMOTE_FRAC_RD = 8'h10;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int SETUP_MASK_BIT = 7;
  localparam int SETUP_STANDBY_BIT = 6;
  localparam int SETUP_ROLE_BIT = 5;
  localparam int SETUP_RANGE_BIT = 2;
  localparam logic [7:0] SETUP_WRITABLE = 8'hE4;
  localparam logic [7:0] SETUP_RESET = 8'h00;
  localparam logic [7:0] RATE_RESET = 8'h08;
  localparam logic [3:0] RATE_CODE_MAX = 4'hA;
  localparam logic [7:0] RESULT_RESET = 8'h00;

  // ****************************************************************
  // Temperature format
  // ****************************************************************
  localparam int ADC_WIDTH = 10;
  localparam logic [9:0] EXT_OFFSET = 10'h040;
  localparam logic [9:0] DEF_MAX = 10'h07F;
  localparam logic [9:0] EXT_MAX = 10'h0FF;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam longint CLK_HZ = 20000000;
  localparam longint SLOWEST_INTERVAL_S = 16;
  localparam longint SLOWEST_INTERVAL_CYC = SLOWEST_INTERVAL_S * CLK_HZ;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    TRCR_IDLE = 3'b001,
    TRCR_LOCAL = 3'b010,
    TRCR_REMOTE = 3'b100
  } trcr_state_t;

  typedef struct packed {
    logic first;
    logic [7:0] data;
  } trcr_wr_byte_t;

  typedef struct packed {
    logic diode_short;
    logic signed [9:0] temp;
  } trcr_adc_t;

endpackage : trcr_pkg

// *** verification/trcr_core_monitor.sv ***
`timescale 1ns/1ps
module trcr_core_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_valid,
  input wire trcr_pkg::trcr_wr_byte_t wr_byte,
  input wire logic rd_req,
  input wire logic [7:0] rd_data,
  input wire logic conv_req,
  input wire logic conv_remote,
  input wire logic adc_done,
  input wire logic results_updated,
  input wire logic alarm_mask_bit,
  input wire logic shared_pin_role_select,
  input wire logic standby,
  input wire logic extended_range
);
  logic [7:0] ptr_r;
  logic [7:0] rate_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_r <= 8'h00;
      rate_r <= 8'h08;
    end else if (wr_valid && wr_byte.first) begin
      ptr_r <= wr_byte.data;
    end else if (wr_valid && ptr_r == 8'h0A) begin
      rate_r <= wr_byte.data;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr;
    wr_valid && !wr_byte.first && ptr_r == 8'h09;
  endsequence
  property p_mask; s_wr |=> alarm_mask_bit == $past(wr_byte.data[7]); endproperty
  a_mask: assert property (p_mask) else $error("mask bit");
  property p_stby; s_wr |=> standby == $past(wr_byte.data[6]); endproperty
  a_stby: assert property (p_stby) else $error("standby bit");
  property p_role; s_wr |=> shared_pin_role_select == $past(wr_byte.data[5]); endproperty
  a_role: assert property (p_role) else $error("role bit");
  property p_range; s_wr |=> extended_range == $past(wr_byte.data[2]); endproperty
  a_range: assert property (p_range) else $error("range bit");
  property p_rate; rd_req && ptr_r == 8'h04 |=> rd_data == $past(rate_r); endproperty
  a_rate: assert property (p_rate) else $error("rate read");
  property p_frac; rd_req && ptr_r == 8'h10 |=> rd_data[5:0] == 6'h00; endproperty
  a_frac: assert property (p_frac) else $error("fraction low bits");
  property p_remote; conv_req && conv_remote |-> $past(adc_done); endproperty
  a_remote: assert property (p_remote) else $error("remote start");
  property p_upd; results_updated |-> $past(adc_done && conv_remote); endproperty
  a_upd: assert property (p_upd) else $error("update pulse");
  property p_start; conv_req && !conv_remote |-> !$past(standby) || !$past(standby, 2); endproperty
  a_start: assert property (p_start) else $error("start in standby");
  c_remote: cover property (conv_req && conv_remote);
  c_upd: cover property (results_updated);
  c_frac: cover property (rd_req && ptr_r == 8'h10);
endmodule : trcr_core_monitor
bind trcr_core trcr_core_monitor u_trcr_core_monitor (.clk(clk), .rst_n(rst_n), .wr_valid(wr_valid),
  .wr_byte(wr_byte), .rd_req(rd_req), .rd_data(rd_data), .conv_req(conv_req), .conv_remote(conv_remote),
  .adc_done(adc_done), .results_updated(results_updated), .alarm_mask_bit(alarm_mask_bit),
  .shared_pin_role_select(shared_pin_role_select), .standby(standby), .extended_range(extended_range));

// *** verification/trcr_adc_model.sv ***
`timescale 1ns/1ps
module trcr_adc_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic conv_req,
  input wire logic conv_remote,
  input wire logic short_d,
  input wire logic [9:0] loc_t,
  input wire logic [9:0] rem_t,
  output logic adc_done,
  output trcr_pkg::trcr_adc_t adc_result
);
  logic [2:0] cnt_r;
  logic ch_r;
  // Result is only valid with done; otherwise it toggles every cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 3'h0;
      ch_r <= 1'b0;
      adc_done <= 1'b0;
      adc_result <= '0;
    end else begin
      adc_done <= cnt_r == 3'h1;
      cnt_r <= conv_req ? 3'h4 : (cnt_r != 3'h0 ? cnt_r - 3'h1 : 3'h0);
      if (conv_req) ch_r <= conv_remote;
      adc_result <= cnt_r == 3'h1 ? (ch_r ? {short_d, rem_t} : {1'b0, loc_t}) : ~adc_result;
    end
  end
endmodule : trcr_adc_model

// *** verification/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr_valid = 1'b0;
  trcr_pkg::trcr_wr_byte_t wr_byte = '0;
  logic rd_req = 1'b0;
  logic [7:0] rd_data;
  logic conv_req, conv_remote, adc_done, upd, mask_o, role_o, stby_o, ext_o;
  trcr_pkg::trcr_adc_t adc_result;
  logic [9:0] loc_t = 10'h3D8;
  logic [9:0] rem_t = 10'h0CB;
  logic short_d = 1'b0;
  int failures = 0;
  int tests_run = 0;
  always #25 clk = ~clk;
  trcr_core #(.SLOW_CYCLES(65536)) u_trcr_core (.clk(clk), .rst_n(rst_n), .wr_valid(wr_valid),
    .wr_byte(wr_byte), .rd_req(rd_req), .rd_data(rd_data), .conv_req(conv_req), .conv_remote(conv_remote),
    .adc_done(adc_done), .adc_result(adc_result), .results_updated(upd), .alarm_mask_bit(mask_o),
    .shared_pin_role_select(role_o), .standby(stby_o), .extended_range(ext_o));
  trcr_adc_model u_trcr_adc_model (.clk(clk), .rst_n(rst_n), .conv_req(conv_req), .conv_remote(conv_remote),
    .short_d(short_d), .loc_t(loc_t), .rem_t(rem_t), .adc_done(adc_done), .adc_result(adc_result));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic put(input logic first, input logic [7:0] data);
    @(posedge clk) #1 wr_valid = 1'b1;
    wr_byte = '{first, data};
    @(posedge clk) #1 wr_valid = 1'b0;
  endtask : put
  task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
    put(1'b1, ptr);
    put(1'b0, data);
  endtask : wr
  task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
    put(1'b1, ptr);
    @(posedge clk) #1 rd_req = 1'b1;
    @(posedge clk) #1 rd_req = 1'b0;
    check(rd_data, exp);
  endtask : rd
  task automatic wait_upd;
    for (int i = 0; i < 1000; i++) begin
      @(negedge clk);
      if (upd === 1'b1) return;
    end
    check(8'h00, 8'h01);
  endtask : wait_upd
  function automatic logic [7:0] exp_int(input logic [9:0] t, input logic ext);
    int v;
    v = ($signed(t) >>> 2) + (ext ? 64 : 0);
    v = v < 0 ? 0 : (v > (ext ? 255 : 127) ? (ext ? 255 : 127) : v);
    return v[7:0];
  endfunction : exp_int
  task automatic t_reset;
    rd(8'h03, 8'h00);
    rd(8'h04, 8'h08);
    rd(8'h02, 8'h00);
    $display("test reset done");
  endtask : t_reset
  task automatic t_setup;
    wr(8'h09, 8'hE4);
    rd(8'h03, 8'hE4);
    check({4'h0, mask_o, stby_o, role_o, ext_o}, 8'h0F);
    wr(8'h09, 8'h00);
    check({4'h0, mask_o, stby_o, role_o, ext_o}, 8'h00);
    $display("test setup done");
  endtask : t_setup
  task automatic t_rate;
    int n;
    wr(8'h0A, 8'h05);
    rd(8'h04, 8'h05);
    rd(8'h0A, 8'h00);
    wr(8'h0A, 8'h0A);
    n = 0;
    while (!(conv_req === 1'b1 && conv_remote === 1'b0) && n < 3000) @(negedge clk) n++;
    n = 0;
    do @(negedge clk) n++; while (!(conv_req === 1'b1 && conv_remote === 1'b0) && n < 3000);
    check(n[7:0], 8'h40);
    $display("test rate done");
  endtask : t_rate
  task automatic t_range;
    for (int e = 0; e < 2; e++) begin
      wr(8'h09, e ? 8'h04 : 8'h00);
      wait_upd;
      wait_upd;
      rd(8'h00, exp_int(loc_t, e[0]));
      rd(8'h10, 8'hC0);
      rd(8'h01, exp_int(rem_t, e[0]));
    end
    $display("test range done");
  endtask : t_range
  task automatic t_lock;
    rd(8'h10, 8'hC0);
    rem_t = 10'h190;
    wait_upd;
    wait_upd;
    rd(8'h01, 8'h72);
    wait_upd;
    rd(8'h01, exp_int(rem_t, 1'b1));
    short_d = 1'b1;
    rem_t = 10'h0C8;
    wait_upd;
    wait_upd;
    rd(8'h01, 8'hA4);
    short_d = 1'b0;
    $display("test lock done");
  endtask : t_lock
  task automatic t_standby;
    int n;
    wait_upd;
    wr(8'h09, 8'h44);
    n = 0;
    repeat (300) @(negedge clk) n += (conv_req === 1'b1);
    check(n[7:0], 8'h00);
    rd(8'h04, 8'h0A);
    wr(8'h09, 8'h04);
    wait_upd;
    $display("test standby done");
  endtask : t_standby
  task automatic print_verdict;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    t_reset();
    t_setup();
    t_rate();
    t_range();
    t_lock();
    t_standby();
    print_verdict();
  end
  initial begin
    #(20000 * 50);
    failures++;
    print_verdict();
  end
endmodule : testbench
